// ---- keypad_irq_pkg.sv ----
// Package for the keypad interrupt block: register map, field positions, reset values.
// Assumes an 8-bit register port with one-cycle strobes and read data one cycle later.
package keypad_irq_pkg;

  // Register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int MAX_PINS = 8;

  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PIN_ENABLE     = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SELECT    = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS     = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR      = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE     = 4'h5;

  // Status and control fields
  localparam int SC_MODE_BIT  = 0;
  localparam int SC_IRQEN_BIT = 1;
  localparam int SC_ACK_BIT   = 2;
  localparam int SC_FLAG_BIT  = 3;

  // Event status fields
  localparam int EVT_W          = 3;
  localparam int EVT_EDGE_BIT   = 0;
  localparam int EVT_LEVEL_BIT  = 1;
  localparam int EVT_REFUSE_BIT = 2;

  // Reset values
  localparam logic [DATA_W-1:0] RST_PIN_ENABLE  = 8'h00;
  localparam logic [DATA_W-1:0] RST_EDGE_SELECT = 8'h00;
  localparam logic              RST_MODE        = 1'b0;
  localparam logic              RST_IRQEN       = 1'b0;
  localparam logic              RST_FLAG        = 1'b0;
  localparam logic [EVT_W-1:0]  RST_EVT         = 3'h0;
  localparam logic [DATA_W-1:0] READ_ZERO       = 8'h00;

  // Polarity encoding
  localparam logic POL_FALL_LOW  = 1'b0;
  localparam logic POL_RISE_HIGH = 1'b1;

  // Detection mode encoding
  localparam logic MODE_EDGE_ONLY  = 1'b0;
  localparam logic MODE_EDGE_LEVEL = 1'b1;

endpackage

// ---- keypad_irq_module.sv ----
// Keypad / external interrupt block: pin sensing, event flag, register port, interrupts.
// Assumes pins are asynchronous, stop and pull controls come from logic on sys_clk.
// Operation
// - Up to eight inputs, each individually enabled
// - One mode bit: edge or edge-plus-level
// - Per-pin polarity: falling/low or rising/high
// - Edge needs prior deasserted sample, clocked
// - Falling edge: high then low sample
// - Rising edge: low then high sample
// - Edge sets flag; ack write clears
// - Flag and irq enable raise request
// - Edge-plus-level: edge or level sets flag
// - Ack clears only when inputs deasserted
// - Asserted input keeps flag through ack
// - Polarity picks pullup or pulldown resistor
// - Ack reads zero; flag not writable
// - Control bits seven to four read zero
// - Stop3 detection works without bus clock
// - Stop1/stop2 disable and reset block
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module keypad_irq_module
  import keypad_irq_pkg::*;
#(
  parameter int NUM_PINS = MAX_PINS
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  input  wire logic [NUM_PINS-1:0] key_pin,
  input  wire logic [NUM_PINS-1:0] port_pull_enable,
  input  wire logic                stop3_mode,
  input  wire logic                stop12_mode,
  output logic [NUM_PINS-1:0]      pull_up_en,
  output logic [NUM_PINS-1:0]      pull_down_en,
  output logic                     key_irq,
  output logic                     stop3_wake,
  output logic                     evt_irq
);

  // Elaboration check on pin count
  if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : g_bad_pins
    $error("NUM_PINS must be between 1 and 8");
  end

  // Register port must hold every pin bit and every event bit
  if (NUM_PINS > DATA_W || EVT_W > DATA_W) begin : g_bad_width
    $error("NUM_PINS and EVT_W must fit the register port");
  end

  // Register map needs indices up to five
  if (ADDR_W < 3) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  // Control registers
  logic [NUM_PINS-1:0] pin_sense_enable_q;
  logic [NUM_PINS-1:0] pin_sense_enable_d;
  logic [NUM_PINS-1:0] polarity_select_q;
  logic [NUM_PINS-1:0] polarity_select_d;
  logic                detect_mode_select_q;
  logic                detect_mode_select_d;
  logic                key_irq_enable_q;
  logic                key_irq_enable_d;

  // Flag and event registers
  logic                key_event_flag_q;
  logic                key_event_flag_d;
  logic [EVT_W-1:0]    evt_status_q;
  logic [EVT_W-1:0]    evt_status_d;
  logic [EVT_W-1:0]    evt_enable_q;
  logic [EVT_W-1:0]    evt_enable_d;

  // Read data
  logic [DATA_W-1:0]   reg_rdata_q;
  logic [DATA_W-1:0]   reg_rdata_d;

  // Pin synchronisers and detection state
  logic [NUM_PINS-1:0] pin_meta_q;
  logic [NUM_PINS-1:0] pin_meta_d;
  logic [NUM_PINS-1:0] pin_sync_q;
  logic [NUM_PINS-1:0] pin_sync_d;
  logic [NUM_PINS-1:0] armed_q;
  logic [NUM_PINS-1:0] armed_d;
  logic [NUM_PINS-1:0] pin_asserted;
  logic [NUM_PINS-1:0] pin_edge;
  logic [NUM_PINS-1:0] raw_asserted;

  // Decoded accesses
  logic                wr_sc;
  logic                wr_pe;
  logic                wr_es;
  logic                wr_eclr;
  logic                wr_een;
  logic                ack_req;
  logic                any_edge;
  logic                any_level;
  logic                flag_set;
  logic                ack_ok;
  logic                ack_refused;
  logic [EVT_W-1:0]    evt_hit;
  logic [DATA_W-1:0]   sc_read;
  logic [DATA_W-1:0]   pe_read;
  logic [DATA_W-1:0]   es_read;
  logic                mode_level;
  logic                all_deasserted;
  logic                wake_src;

  // Write decode
  assign wr_sc   = reg_wr && (reg_addr == ADDR_STATUS_CONTROL);
  assign wr_pe   = reg_wr && (reg_addr == ADDR_PIN_ENABLE);
  assign wr_es   = reg_wr && (reg_addr == ADDR_EDGE_SELECT);
  assign wr_eclr = reg_wr && (reg_addr == ADDR_EVT_CLEAR);
  assign wr_een  = reg_wr && (reg_addr == ADDR_EVT_ENABLE);
  assign ack_req = wr_sc && reg_wdata[SC_ACK_BIT];

  // Two-flop pin synchroniser; the second stage feeds detection, while the stop3 wake path uses key_pin directly
  always_comb begin
    pin_meta_d = key_pin;
    pin_sync_d = pin_meta_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
    end
  end

  // Per-pin sensing
  // one slice per pin
  genvar gi;
  for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
    assign pin_asserted[gi] = pin_sense_enable_q[gi] &&
                              ((polarity_select_q[gi] == POL_RISE_HIGH) ? pin_sync_q[gi] : !pin_sync_q[gi]);
    assign pin_edge[gi]     = armed_q[gi] && pin_asserted[gi];
    assign raw_asserted[gi] = pin_sense_enable_q[gi] &&
                              ((polarity_select_q[gi] == POL_RISE_HIGH) ? key_pin[gi] : !key_pin[gi]);
    assign pull_up_en[gi]   = port_pull_enable[gi] && (polarity_select_q[gi] == POL_FALL_LOW);
    assign pull_down_en[gi] = port_pull_enable[gi] && (polarity_select_q[gi] == POL_RISE_HIGH);
  end

  always_comb begin
    armed_d = pin_sense_enable_q & ~pin_asserted;
    if (stop12_mode) begin
      armed_d = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed_q <= '0;
    end else begin
      armed_q <= armed_d;
    end
  end

  assign mode_level     = (detect_mode_select_q == MODE_EDGE_LEVEL);
  assign all_deasserted = !(|pin_asserted);

  assign any_edge  = |pin_edge;
  assign any_level = mode_level && !all_deasserted;
  assign flag_set  = any_edge || any_level;

  assign ack_ok      = ack_req && (!mode_level || all_deasserted);
  assign ack_refused = ack_req && !ack_ok;

  // Control register next values
  always_comb begin
    pin_sense_enable_d   = pin_sense_enable_q;
    polarity_select_d    = polarity_select_q;
    detect_mode_select_d = detect_mode_select_q;
    key_irq_enable_d     = key_irq_enable_q;
    evt_enable_d         = evt_enable_q;
    if (wr_pe) begin
      pin_sense_enable_d = reg_wdata[NUM_PINS-1:0];
    end
    if (wr_es) begin
      polarity_select_d = reg_wdata[NUM_PINS-1:0];
    end
    if (wr_sc) begin
      detect_mode_select_d = reg_wdata[SC_MODE_BIT];
      key_irq_enable_d     = reg_wdata[SC_IRQEN_BIT];
    end
    if (wr_een) begin
      evt_enable_d = reg_wdata[EVT_W-1:0];
    end
    if (stop12_mode) begin
      pin_sense_enable_d   = RST_PIN_ENABLE[NUM_PINS-1:0];
      polarity_select_d    = RST_EDGE_SELECT[NUM_PINS-1:0];
      detect_mode_select_d = RST_MODE;
      key_irq_enable_d     = RST_IRQEN;
      evt_enable_d         = RST_EVT;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_sense_enable_q   <= RST_PIN_ENABLE[NUM_PINS-1:0];
      polarity_select_q    <= RST_EDGE_SELECT[NUM_PINS-1:0];
      detect_mode_select_q <= RST_MODE;
      key_irq_enable_q     <= RST_IRQEN;
      evt_enable_q         <= RST_EVT;
    end else begin
      pin_sense_enable_q   <= pin_sense_enable_d;
      polarity_select_q    <= polarity_select_d;
      detect_mode_select_q <= detect_mode_select_d;
      key_irq_enable_q     <= key_irq_enable_d;
      evt_enable_q         <= evt_enable_d;
    end
  end

  // Event flag next value
  always_comb begin
    key_event_flag_d = key_event_flag_q;
    if (ack_ok) begin
      key_event_flag_d = 1'b0;
    end
    if (flag_set) begin
      key_event_flag_d = 1'b1;
    end
    if (stop12_mode) begin
      key_event_flag_d = RST_FLAG;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      key_event_flag_q <= RST_FLAG;
    end else begin
      key_event_flag_q <= key_event_flag_d;
    end
  end

  // Sticky event status
  always_comb begin
    evt_hit                 = '0;
    evt_hit[EVT_EDGE_BIT]   = any_edge;
    evt_hit[EVT_LEVEL_BIT]  = any_level;
    evt_hit[EVT_REFUSE_BIT] = ack_refused;
    evt_status_d            = evt_status_q;
    if (wr_eclr) begin
      evt_status_d = evt_status_q & ~reg_wdata[EVT_W-1:0];
    end
    evt_status_d = evt_status_d | evt_hit;
    if (stop12_mode) begin
      evt_status_d = RST_EVT;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_status_q <= RST_EVT;
    end else begin
      evt_status_q <= evt_status_d;
    end
  end

  always_comb begin
    sc_read               = READ_ZERO;
    sc_read[SC_MODE_BIT]  = detect_mode_select_q;
    sc_read[SC_IRQEN_BIT] = key_irq_enable_q;
    sc_read[SC_FLAG_BIT]  = key_event_flag_q;
    pe_read               = READ_ZERO;
    pe_read[NUM_PINS-1:0] = pin_sense_enable_q;
    es_read               = READ_ZERO;
    es_read[NUM_PINS-1:0] = polarity_select_q;
  end

  // Read data mux, registered
  always_comb begin
    reg_rdata_d = READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS_CONTROL: begin
          reg_rdata_d = sc_read;
        end
        ADDR_PIN_ENABLE: begin
          reg_rdata_d = pe_read;
        end
        ADDR_EDGE_SELECT: begin
          reg_rdata_d = es_read;
        end
        ADDR_EVT_STATUS: begin
          reg_rdata_d[EVT_W-1:0] = evt_status_q;
        end
        ADDR_EVT_ENABLE: begin
          reg_rdata_d[EVT_W-1:0] = evt_enable_q;
        end
        default: begin
          reg_rdata_d = READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= READ_ZERO;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign reg_rdata = reg_rdata_q;

  assign key_irq    = key_event_flag_q && key_irq_enable_q;
  assign wake_src   = (|raw_asserted) || key_event_flag_q;
  assign stop3_wake = stop3_mode && key_irq_enable_q && wake_src;
  assign evt_irq    = |(evt_status_q & evt_enable_q);

endmodule // keypad_irq_module

`default_nettype wire

// ---- keypad_irq_chk.sv ----
// Port checker for keypad_irq_module.
// Assumes a bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module keypad_irq_chk
  import keypad_irq_pkg::*;
#(parameter int NUM_PINS = MAX_PINS) (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  input wire logic [NUM_PINS-1:0] key_pin,
  input wire logic [NUM_PINS-1:0] port_pull_enable,
  input wire logic                stop3_mode,
  input wire logic                stop12_mode,
  input wire logic [NUM_PINS-1:0] pull_up_en,
  input wire logic [NUM_PINS-1:0] pull_down_en,
  input wire logic                key_irq,
  input wire logic                stop3_wake,
  input wire logic                evt_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_irq_masked: assert property (
    reg_wr && reg_addr == ADDR_STATUS_CONTROL && !reg_wdata[SC_IRQEN_BIT] |=> !key_irq)
    else $error("request with enable clear");
  a_pull_excl: assert property (
    (pull_up_en & pull_down_en) == '0) else $error("both pulls on");
  a_pull_cover: assert property (
    (pull_up_en | pull_down_en) == port_pull_enable) else $error("pull not per enable");
  a_ctrl_zeros: assert property (
    $past(reg_rd) && $past(reg_addr) == ADDR_STATUS_CONTROL |-> reg_rdata[7:4] == 4'h0)
    else $error("upper control bits set");
  a_ack_reads0: assert property (
    $past(reg_rd) && $past(reg_addr) == ADDR_STATUS_CONTROL |-> !reg_rdata[SC_ACK_BIT])
    else $error("ack bit reads one");
  a_flag_sticky: assert property (
    key_irq && !(reg_wr && reg_addr == ADDR_STATUS_CONTROL) && !stop12_mode |=> key_irq)
    else $error("flag dropped alone");
  a_flag_ro: assert property (
    key_irq && reg_wr && reg_addr == ADDR_STATUS_CONTROL && reg_wdata[SC_IRQEN_BIT]
    && !reg_wdata[SC_ACK_BIT] && !stop12_mode |=> key_irq) else $error("flag cleared by write");
  a_stop_clear: assert property (
    stop12_mode |=> !key_irq && !evt_irq) else $error("stop left state");
  a_wake_gate: assert property (
    !stop3_mode |-> !stop3_wake) else $error("wake outside stop3");
endmodule // keypad_irq_chk
`default_nettype wire

// ---- key_source.sv ----
// Key switch model: driven level, else pull level, else a toggling value.
// Assumes pull enables come from the block under test.
`timescale 1ns/1ps
`default_nettype none
module key_source (
  input  wire logic       sys_clk,
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  input  wire logic [7:0] pull_up_en,
  input  wire logic [7:0] pull_down_en,
  output logic      [7:0] key_pin
);
  logic tgl_q = 1'b0;
  always_ff @(posedge sys_clk) tgl_q <= ~tgl_q;
  always_comb
    for (int i = 0; i < 8; i++)
      key_pin[i] = drv_en[i] ? drv_val[i] : pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : tgl_q;
endmodule // key_source
`default_nettype wire

// ---- tb_top.sv ----
// Bench: table of pin edge cases, then reset, level, stop and pull tests.
// Assumes key_source drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import keypad_irq_pkg::*;
;
  logic       sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, stop3_mode = 0, stop12_mode = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, drv_en = 8'hFF, drv_val = 8'hFF, port_pull_enable = 8'h00;
  logic [7:0] reg_rdata, key_pin, pull_up_en, pull_down_en;
  logic       key_irq, stop3_wake, evt_irq;
  int         n_fail = 0, compares = 0, cycles = 0, p;
  logic [4:0] r;
  // Row: pin enable, polarity, start level, end level, expected flag
  logic [4:0] rows [6] = '{5'h15, 5'h12, 5'h1B, 5'h1C, 5'h04, 5'h1B};
  keypad_irq_module uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_pin(key_pin),
    .port_pull_enable(port_pull_enable), .stop3_mode(stop3_mode), .stop12_mode(stop12_mode),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .key_irq(key_irq),
    .stop3_wake(stop3_wake), .evt_irq(evt_irq));
  key_source src (.sys_clk(sys_clk), .drv_en(drv_en), .drv_val(drv_val), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .key_pin(key_pin));
  always #50 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    cyc(6);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      p = 7 - i;
      r = rows[i];
      wr(ADDR_STATUS_CONTROL, 8'h00);
      wr(ADDR_EDGE_SELECT, 8'(r[3]) << p);
      drv_val[p] <= r[2];
      cyc(3);
      wr(ADDR_PIN_ENABLE, 8'(r[4]) << p);
      cyc(3);
      wr(ADDR_STATUS_CONTROL, 8'h06);
      drv_val[p] <= r[1];
      cyc(5);
      #1 chk("key_irq", {7'h00, key_irq}, {7'h00, r[0]});
      rd(ADDR_STATUS_CONTROL, {4'h0, r[0], 3'h2});
      wr(ADDR_STATUS_CONTROL, 8'h06);
      rd(ADDR_STATUS_CONTROL, 8'h02);
      $display("row %0d done", i);
    end
    rd(ADDR_EVT_STATUS, 8'h01);
    @(posedge sys_clk) rst <= 1'b1;
    drv_val <= 8'hFE;
    cyc(2);
    rst <= 1'b0;
    rd(ADDR_STATUS_CONTROL, 8'h00);
    rd(ADDR_PIN_ENABLE, 8'h00);
    rd(ADDR_EDGE_SELECT, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(ADDR_STATUS_CONTROL, 8'hFA);
    rd(ADDR_STATUS_CONTROL, 8'h02);
    $display("reset test done");
    wr(ADDR_PIN_ENABLE, 8'h01);
    wr(ADDR_STATUS_CONTROL, 8'h03);
    cyc(4);
    rd(ADDR_STATUS_CONTROL, 8'h0B);
    wr(ADDR_STATUS_CONTROL, 8'h0B);
    wr(ADDR_STATUS_CONTROL, 8'h07);
    rd(ADDR_STATUS_CONTROL, 8'h0B);
    rd(ADDR_EVT_STATUS, 8'h06);
    wr(ADDR_EVT_ENABLE, 8'h04);
    #1 chk("evt_irq", {7'h00, evt_irq}, 8'h01);
    wr(ADDR_EVT_ENABLE, 8'h00);
    #1 chk("evt_irq", {7'h00, evt_irq}, 8'h00);
    wr(ADDR_EVT_ENABLE, 8'h04);
    wr(ADDR_EVT_CLEAR, 8'h04);
    #1 chk("evt_irq", {7'h00, evt_irq}, 8'h00);
    @(posedge sys_clk) drv_val[0] <= 1'b1;
    cyc(4);
    wr(ADDR_STATUS_CONTROL, 8'h07);
    rd(ADDR_STATUS_CONTROL, 8'h03);
    $display("level test done");
    @(posedge sys_clk) stop3_mode <= 1'b1;
    cyc(1);
    #1 chk("stop3_wake", {7'h00, stop3_wake}, 8'h00);
    @(posedge sys_clk) drv_val[0] <= 1'b0;
    #1 chk("stop3_wake", {7'h00, stop3_wake}, 8'h01);
    @(posedge sys_clk) stop3_mode <= 1'b0;
    stop12_mode <= 1'b1;
    cyc(2);
    #1 chk("key_irq", {7'h00, key_irq}, 8'h00);
    @(posedge sys_clk) stop12_mode <= 1'b0;
    rd(ADDR_STATUS_CONTROL, 8'h00);
    $display("stop test done");
    @(posedge sys_clk) port_pull_enable <= 8'hFF;
    wr(ADDR_EDGE_SELECT, 8'h0F);
    drv_en <= 8'h00;
    #1 chk("pull_down_en", pull_down_en, 8'h0F);
    chk("pull_up_en", pull_up_en, 8'hF0);
    $display("pull test done");
    give_verdict();
  end
endmodule // tb_top
bind keypad_irq_module keypad_irq_chk #(.NUM_PINS(NUM_PINS)) chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .key_pin(key_pin), .port_pull_enable(port_pull_enable),
  .stop3_mode(stop3_mode), .stop12_mode(stop12_mode), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .key_irq(key_irq), .stop3_wake(stop3_wake), .evt_irq(evt_irq));
`default_nettype wire
